// File: verilog/ssr_defs.svh
// Register offsets, field positions, reset values and constants of the SPI status block
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SSR_OFS_PORT_CTRL   16'hc0ca
`define SSR_OFS_IRQ_ENABLE  16'hc0cc
`define SSR_OFS_IRQ_STATUS  16'hc0ce
`define SSR_OFS_IRQ_CLEAR   16'hc0d0
`define SSR_OFS_CRC_CONTROL 16'hc0d2
`define SSR_OFS_CRC_VALUE   16'hc0d4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSR_CTL_FIFO_INIT   14
`define SSR_CTL_TX_EMPTY    7
`define SSR_CTL_RX_FULL     6
`define SSR_BIT_FIFO_ERR    7
`define SSR_BIT_BYTE_RX     2
`define SSR_BIT_BYTE_TX     1
`define SSR_BIT_BLOCK       0
`define SSR_CRC_POLY_HI     15
`define SSR_CRC_POLY_LO     14
`define SSR_CRC_ENABLE      13
`define SSR_CRC_CLEAR       12
`define SSR_CRC_FROM_RX     11
`define SSR_CRC_ONE_IN      10
`define SSR_CRC_ZERO_IN     9

// ----------------------------------------------------------------
// Reset values and polynomials
// ----------------------------------------------------------------
`define SSR_RST_REG         16'h0000
`define SSR_CRC_PRESET      16'hffff
`define SSR_CRC7_MASK       16'h007f
`define SSR_POLY_CCITT      16'h1021
`define SSR_POLY_CRC7       16'h0009
`define SSR_POLY_ALT16      16'h8005

`endif

// File: verilog/ssr_pkg.sv
// Types shared by the SPI status block
package ssr_pkg;

	// CRC polynomial choice
	typedef enum logic [1:0] {
		POLY_CCITT = 2'b00,
		POLY_CRC7  = 2'b01,
		POLY_ALT16 = 2'b10,
		POLY_RSVD  = 2'b11
	} ssr_poly_e;

	// Link framing state
	typedef enum logic {
		LINK_IDLE  = 1'b0,
		LINK_FRAME = 1'b1
	} ssr_link_e;

endpackage

// File: verilog/ssr_sticky_flag.sv
// Sticky event flag where a set beats a simultaneous clear
`timescale 1ns/1ps

module ssr_sticky_flag (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic srst,
	// Event and clear
	input  wire logic setEvt,
	input  wire logic clrEvt,
	// Flag
	output logic      flag
);

	// Set wins so an event in the clearing cycle is not lost
	always_ff @(posedge core_clk) begin
		if (srst) begin
			flag <= 1'b0;
		end else if (setEvt) begin
			flag <= 1'b1;
		end else if (clrEvt) begin
			flag <= 1'b0;
		end
	end

endmodule

// File: verilog/ssr_crc_engine.sv
// Bit-serial CRC register with selectable polynomial and all-ones preset
`timescale 1ns/1ps
`include "ssr_defs.svh"

module ssr_crc_engine
	import ssr_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// Control
	input  ssr_poly_e        polySel,
	input  wire logic        preset,
	input  wire logic        bitEn,
	input  wire logic        bitIn,
	// CRC value
	output logic      [15:0] crcR
);

	// ----------------------------------------------------------------
	// Next value
	// ----------------------------------------------------------------
	wire logic        is7     = (polySel == POLY_CRC7);
	wire logic        topBit  = is7 ? crcR[6] : crcR[15];
	wire logic        fb      = bitIn ^ topBit;
	// Reserved code runs the first 16-bit polynomial
	wire logic [15:0] polyVal = (polySel == POLY_CRC7)  ? `SSR_POLY_CRC7 :
	                            (polySel == POLY_ALT16) ? `SSR_POLY_ALT16 :
	                            `SSR_POLY_CCITT; // RULE15
	wire logic [15:0] widthMsk = is7 ? `SSR_CRC7_MASK : `SSR_CRC_PRESET;
	wire logic [15:0] stepVal  = ({crcR[14:0], 1'b0} ^ (fb ? polyVal : 16'h0000)) & widthMsk;

	// Preset beats a shift in the same cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			crcR <= `SSR_CRC_PRESET;
		end else if (preset) begin
			crcR <= `SSR_CRC_PRESET; // RULE16
		end else if (bitEn) begin
			crcR <= stepVal;
		end
	end

endmodule

// File: verilog/ssr_status_regs.sv
// SPI port status, interrupt enable/clear, bit-length and CRC control registers
//
// Summary of operation
// RULE1 - Control bit 6 shows receive FIFO full
// RULE2 - Bits 5:3 give last transmitted byte length
// RULE3 - Bits 2:0 give last received byte length
// RULE4 - Enable bit 2 gates receive interrupt, resets zero
// RULE5 - Enable bit 1 gates transmit interrupt
// RULE6 - Enable bit 0 gates block done interrupt
// RULE7 - Status bit 7 flags a FIFO fault
// RULE8 - FIFO init write alone clears FIFO error
// RULE9 - Status bit 2 shows receive interrupt triggered
// RULE10 - Status bit 1 shows transmit interrupt triggered
// RULE11 - Status bit 0 shows block interrupt triggered
// RULE12 - Clear bit 1 clears transmit flag, self-clearing
// RULE13 - Clear bit 0 clears block flag, self-clearing
// RULE14 - Software writes zero to reserved bits
// RULE15 - Two-bit select picks the CRC polynomial
// RULE16 - CRC clear bit presets all ones, reads zero
// RULE17 - Source bit picks rx or tx stream
// RULE18 - Bits 10/9 flag CRC not zero/not ones
// RULE19 - Interrupt request when enabled flag is set
// RULE20 - Receive flag drops when receive data drained
`timescale 1ns/1ps
`include "ssr_defs.svh"

module ssr_status_regs
	import ssr_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// Register port
	input  wire logic [15:0] regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdData,
	// Rest of the SPI port, same clock
	input  wire logic        txEmpty,
	input  wire logic        rxFull,
	input  wire logic        fifoFault,
	input  wire logic        rxDataReady,
	input  wire logic        byteRxEvt,
	input  wire logic        byteTxEvt,
	input  wire logic        blockDoneEvt,
	input  wire logic        masterMode,
	input  wire logic        fullDuplex,
	input  wire logic        readEnable,
	input  wire logic        sampleOnRise,
	output logic             fifoInitPulse,
	output logic      [15:0] crcValue,
	// SPI pins, asynchronous
	input  wire logic        sckPin,
	input  wire logic        selectNPin,
	input  wire logic        mosiPin,
	input  wire logic        misoPin,
	// Interrupt request to the processor
	output logic             irqReq
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] pinS1;    // First stage, read only by the second
	logic [3:0] pinS2;    // Stable copies: sck, select, mosi, miso
	logic       sckS3;    // Previous sck, for edge detection

	// Two flops before any logic looks at a pin
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pinS1 <= 4'h2;
			pinS2 <= 4'h2;
			sckS3 <= 1'b0;
		end else begin
			pinS1 <= {misoPin, mosiPin, selectNPin, sckPin};
			pinS2 <= pinS1;
			sckS3 <= pinS2[0];
		end
	end

	wire logic sckNow   = pinS2[0];
	wire logic selNow   = pinS2[1];  // Low while a frame is open
	wire logic mosiNow  = pinS2[2];
	wire logic misoNow  = pinS2[3];
	wire logic sckRise  = sckNow & ~sckS3;
	wire logic sckFall  = ~sckNow & sckS3;
	wire logic sampleEd = sampleOnRise ? sckRise : sckFall;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire logic hitCtrl  = (regAddr == `SSR_OFS_PORT_CTRL);
	wire logic hitEn    = (regAddr == `SSR_OFS_IRQ_ENABLE);
	wire logic hitStat  = (regAddr == `SSR_OFS_IRQ_STATUS);
	wire logic hitClr   = (regAddr == `SSR_OFS_IRQ_CLEAR);
	wire logic hitCrcC  = (regAddr == `SSR_OFS_CRC_CONTROL);
	wire logic hitCrcV  = (regAddr == `SSR_OFS_CRC_VALUE);
	wire logic wrCtrl   = regWr & hitCtrl;
	wire logic wrEn     = regWr & hitEn;
	wire logic wrClr    = regWr & hitClr;
	wire logic wrCrcC   = regWr & hitCrcC;

	// Write-one strobes; nothing is stored so they self-clear
	wire logic fifoInitWr = wrCtrl & regWrData[`SSR_CTL_FIFO_INIT];
	wire logic txClrWr    = wrClr & regWrData[`SSR_BIT_BYTE_TX];   // RULE12
	wire logic blkClrWr   = wrClr & regWrData[`SSR_BIT_BLOCK];     // RULE13
	wire logic crcClrWr   = wrCrcC & regWrData[`SSR_CRC_CLEAR];    // RULE16

	// ----------------------------------------------------------------
	// Software-held control
	// ----------------------------------------------------------------
	logic [2:0] irqEnR;       // Receive, transmit, block enables
	ssr_poly_e  polySelR;     // CRC polynomial choice
	logic       crcEnR;       // CRC runs while set
	logic       crcFromRxR;   // Full duplex CRC source

	// Reserved bits are dropped, so stray ones do no harm
	always_ff @(posedge core_clk) begin
		if (srst) begin
			irqEnR     <= 3'h0;
			polySelR   <= POLY_CCITT;
			crcEnR     <= 1'b0;
			crcFromRxR <= 1'b0;
		end else begin
			if (wrEn) begin
				irqEnR <= regWrData[2:0]; // RULE4 RULE5 RULE6
			end
			if (wrCrcC) begin
				polySelR   <= ssr_poly_e'(regWrData[`SSR_CRC_POLY_HI:`SSR_CRC_POLY_LO]);
				crcEnR     <= regWrData[`SSR_CRC_ENABLE];
				crcFromRxR <= regWrData[`SSR_CRC_FROM_RX];
			end
		end
	end

	// FIFO init pulse to the FIFO, one cycle after the write
	always_ff @(posedge core_clk) begin
		if (srst) begin
			fifoInitPulse <= 1'b0;
		end else begin
			fifoInitPulse <= fifoInitWr;
		end
	end

	// ----------------------------------------------------------------
	// Event flags
	// ----------------------------------------------------------------
	logic fifoErrFlag;  // FIFO fault seen
	logic rxFlag;       // Byte receive triggered
	logic txFlag;       // Byte transmit triggered
	logic blkFlag;      // Block transfer done

	// Only a FIFO init clears the error; a fault in that cycle still sets it
	ssr_sticky_flag uFifoErr (
		.core_clk (core_clk),
		.srst     (srst),
		.setEvt   (fifoFault),   // RULE7
		.clrEvt   (fifoInitWr),  // RULE8
		.flag     (fifoErrFlag)
	);

	// No clear bit exists, so the flag follows the receive data away
	ssr_sticky_flag uRxFlag (
		.core_clk (core_clk),
		.srst     (srst),
		.setEvt   (byteRxEvt),     // RULE9
		.clrEvt   (~rxDataReady),  // RULE20
		.flag     (rxFlag)
	);

	ssr_sticky_flag uTxFlag (
		.core_clk (core_clk),
		.srst     (srst),
		.setEvt   (byteTxEvt),  // RULE10
		.clrEvt   (txClrWr),    // RULE12
		.flag     (txFlag)
	);

	ssr_sticky_flag uBlkFlag (
		.core_clk (core_clk),
		.srst     (srst),
		.setEvt   (blockDoneEvt),  // RULE11
		.clrEvt   (blkClrWr),      // RULE13
		.flag     (blkFlag)
	);

	// Any enabled flag raises the request
	wire logic [2:0] flagVec = {rxFlag, txFlag, blkFlag};
	wire logic       irqNxt  = |(flagVec & irqEnR); // RULE19

	always_ff @(posedge core_clk) begin
		if (srst) begin
			irqReq <= 1'b0;
		end else begin
			irqReq <= irqNxt;
		end
	end

	// ----------------------------------------------------------------
	// Link framing and bit-length capture
	// ----------------------------------------------------------------
	ssr_link_e  linkR;     // Frame state
	logic [2:0] bitCntR;   // Bits in the current byte, modulo eight
	logic [2:0] txLenR;    // Last transmitted byte length
	logic [2:0] rxLenR;    // Last received byte length

	// Which directions moved data in the closing frame
	wire logic txActive = fullDuplex | ~readEnable;
	wire logic rxActive = fullDuplex | readEnable;

	// The count wraps at eight, so a whole byte leaves zero
	always_ff @(posedge core_clk) begin
		if (srst) begin
			linkR   <= LINK_IDLE;
			bitCntR <= 3'h0;
			txLenR  <= 3'h0;
			rxLenR  <= 3'h0;
		end else begin
			case (linkR)
				LINK_IDLE: begin
					if (!selNow) begin
						linkR   <= LINK_FRAME;
						bitCntR <= 3'h0;
					end
				end
				LINK_FRAME: begin
					if (selNow) begin
						linkR <= LINK_IDLE;
						if (txActive) begin
							txLenR <= bitCntR; // RULE2
						end
						if (rxActive) begin
							rxLenR <= bitCntR; // RULE3
						end
					end else if (sampleEd) begin
						bitCntR <= bitCntR + 3'h1;
					end
				end
				default: begin
					linkR <= LINK_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// CRC input and engine
	// ----------------------------------------------------------------
	// Master receives on miso, slave on mosi
	wire logic rxBit  = masterMode ? misoNow : mosiNow;
	wire logic txBit  = masterMode ? mosiNow : misoNow;
	// In half duplex the lines are tied, so the source bit is ignored
	wire logic crcBit = (fullDuplex & ~crcFromRxR) ? txBit : rxBit; // RULE17
	wire logic crcEn  = crcEnR & (linkR == LINK_FRAME) & ~selNow & sampleEd;

	ssr_crc_engine uCrc (
		.core_clk (core_clk),
		.srst     (srst),
		.polySel  (polySelR),
		.preset   (crcClrWr),
		.bitEn    (crcEn),
		.bitIn    (crcBit),
		.crcR     (crcValue)
	);

	// Flags look only at the bits the polynomial uses
	wire logic [15:0] crcMsk   = (polySelR == POLY_CRC7) ? `SSR_CRC7_MASK : `SSR_CRC_PRESET;
	wire logic        oneInCrc = |(crcValue & crcMsk);               // RULE18
	wire logic        zeroInCrc = ((crcValue & crcMsk) != crcMsk);   // RULE18

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	wire logic [15:0] ctrlWord = {8'h00, txEmpty, rxFull, txLenR, rxLenR}; // RULE1
	wire logic [15:0] enWord   = {13'h0000, irqEnR};
	wire logic [15:0] statWord = {8'h00, fifoErrFlag, 4'h0, flagVec};
	// Clear bit always reads zero
	wire logic [15:0] crcCWord = {polySelR, crcEnR, 1'b0, crcFromRxR,
	                              oneInCrc, zeroInCrc, 9'h000};
	// Clear register is write-only; unmapped reads give zero
	wire logic [15:0] rdMux    = hitCtrl ? ctrlWord :
	                             hitEn   ? enWord   :
	                             hitStat ? statWord :
	                             hitCrcC ? crcCWord :
	                             hitCrcV ? crcValue :
	                             `SSR_RST_REG;

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (srst) begin
			regRdData <= `SSR_RST_REG;
		end else if (regRd) begin
			regRdData <= rdMux;
		end else begin
			regRdData <= `SSR_RST_REG;
		end
	end

endmodule

// File: bench/ssr_status_regs_properties.sv
// Checker for the register port, event flags and interrupt request of the SPI status block
`timescale 1ns/1ps

module ssr_status_regs_properties (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        srst,
	// Register port
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [15:0] regRdData,
	// Events and outputs
	input wire logic        byteRxEvt,
	input wire logic        byteTxEvt,
	input wire logic        blockDoneEvt,
	input wire logic        fifoInitPulse,
	input wire logic [15:0] crcValue,
	input wire logic        irqReq
);
	logic [2:0] enSh_r;   // Mirror of the enable bits
	logic [1:0] modeSh_r; // Mirror of the polynomial select

	// ----------------------------------------------------------------
	// Shadow registers
	// ----------------------------------------------------------------
	// Follows software writes so enables are known without peeking inside
	always_ff @(posedge core_clk) begin
		if (srst) begin
			enSh_r <= 3'h0;
			modeSh_r <= 2'h0;
		end else if (regWr && regAddr == 16'hc0cc) begin
			enSh_r <= regWrData[2:0];
		end else if (regWr && regAddr == 16'hc0d2) begin
			modeSh_r <= regWrData[15:14];
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	chk_rx_irq_raise: assert property (byteRxEvt && enSh_r[2] && !regWr |-> ##2 irqReq)
		else $error("receive event did not raise the request");
	chk_tx_irq_raise: assert property (byteTxEvt && enSh_r[1] && !regWr |-> ##2 irqReq)
		else $error("transmit event did not raise the request");
	chk_blk_irq_raise: assert property (blockDoneEvt && enSh_r[0] && !regWr |-> ##2 irqReq)
		else $error("block event did not raise the request");
	chk_irq_quiet: assert property (enSh_r == 3'h0 |=> !irqReq)
		else $error("request high with all enables off");
	chk_read_window: assert property (!regRd |=> regRdData == 16'h0000)
		else $error("read data outside its cycle");
	chk_enable_readback: assert property (regRd && regAddr == 16'hc0cc
		|=> regRdData == {13'h0000, $past(enSh_r)})
		else $error("enable register read back wrong");
	chk_clear_reads_zero: assert property (regRd && regAddr == 16'hc0d0 |=> regRdData == 16'h0000)
		else $error("clear register read nonzero");
	chk_init_pulse: assert property (regWr && regAddr == 16'hc0ca && regWrData[14]
		|=> fifoInitPulse)
		else $error("init write gave no pulse");
	chk_init_cause: assert property (fifoInitPulse
		|-> $past(regWr && regAddr == 16'hc0ca && regWrData[14]))
		else $error("init pulse without init write");
	chk_crc_status_bits: assert property (regRd && regAddr == 16'hc0d2 && modeSh_r != 2'b01
		|=> regRdData[10] == $past(|crcValue) && regRdData[9] == $past(crcValue != 16'hffff)
		&& !regRdData[12])
		else $error("crc status bits disagree with crc value");
endmodule

bind ssr_status_regs ssr_status_regs_properties u_props (
	.core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
	.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .byteRxEvt(byteRxEvt),
	.byteTxEvt(byteTxEvt), .blockDoneEvt(blockDoneEvt), .fifoInitPulse(fifoInitPulse),
	.crcValue(crcValue), .irqReq(irqReq)
);

// File: bench/ssr_spi_peer.sv
// Behavioural SPI peer that drives frames onto the block's pins
`timescale 1ns/1ps

module ssr_spi_peer (
	// SPI pins
	output logic sckPin,
	output logic selectNPin,
	output logic mosiPin,
	output logic misoPin
);
	// Idle: clock still, deselected, data lines parked with mosi low and miso high
	initial begin
		sckPin = 1'b0;
		selectNPin = 1'b1;
		mosiPin = 1'b0;
		misoPin = 1'b1;
	end

	// One frame of n bits, MSB first, 320 ns clock, sampled on the rise
	// Miso carries the inverse of mosi, so the two streams give different CRCs
	task automatic frame(input int n, input logic [7:0] dat);
		#7 selectNPin = 1'b0;
		for (int i = 0; i < n; i++) begin
			mosiPin = dat[7 - i];
			misoPin = ~dat[7 - i];
			#160 sckPin = 1'b1;
			#160 sckPin = 1'b0;
		end
		#160 selectNPin = 1'b1;
		// Released lines show the inverse, so stale data cannot pass for valid
		mosiPin = ~mosiPin;
		misoPin = ~misoPin;
	endtask
endmodule

// File: bench/ssr_status_regs_bench.sv
// Self-checking bench for the SPI status, interrupt and CRC control block
`timescale 1ns/1ps
`include "ssr_defs.svh"

module ssr_status_regs_bench;
	logic        core_clk = 1'b0;   // 25 MHz system clock
	logic        srst = 1'b1;       // Synchronous reset
	logic [15:0] regAddr = 16'h0000;
	logic [15:0] regWrData = 16'h0000;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [15:0] d;                 // Last read word
	logic        txEmpty = 1'b1;
	logic        rxFull = 1'b0;
	logic        rxDataReady = 1'b1;
	logic [3:0]  evt = 4'h0;        // Fault, receive, transmit, block pulses
	logic        fullDuplex = 1'b1;
	logic        masterMode = 1'b1;  // Master receives on miso
	logic        readEnable = 1'b0;  // Half duplex direction
	wire  [15:0] regRdData;
	wire  [15:0] crcValue;
	wire         fifoInitPulse;
	wire         irqReq;
	wire         sck;
	wire         sel;
	wire         mosi;
	wire         miso;
	int          bad_count = 0;
	int          checked = 0;

	always #20 core_clk = ~core_clk;

	ssr_spi_peer peer (.sckPin(sck), .selectNPin(sel), .mosiPin(mosi), .misoPin(miso));

	ssr_status_regs DUT (
		.core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .txEmpty(txEmpty),
		.rxFull(rxFull), .fifoFault(evt[3]), .rxDataReady(rxDataReady),
		.byteRxEvt(evt[2]), .byteTxEvt(evt[1]), .blockDoneEvt(evt[0]),
		.masterMode(masterMode), .fullDuplex(fullDuplex), .readEnable(readEnable),
		.sampleOnRise(1'b1), .fifoInitPulse(fifoInitPulse), .crcValue(crcValue),
		.sckPin(sck), .selectNPin(sel), .mosiPin(mosi), .misoPin(miso), .irqReq(irqReq)
	);

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	task wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= v;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask

	// Data is taken at the edge that closes its one valid cycle
	task rchk(input logic [15:0] a, input logic [15:0] e);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		@(posedge core_clk);
		d = regRdData;
		chk(d, e);
	endtask

	task chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task pulse(input logic [3:0] m);
		@(posedge core_clk);
		evt <= m;
		@(posedge core_clk);
		evt <= 4'h0;
	endtask

	// Request follows the flag one cycle later
	task irqchk(input logic e);
		repeat (2) @(posedge core_clk);
		chk({15'h0000, irqReq}, {15'h0000, e});
	endtask

	task conclude;
		$display("counts: checked=%0d mismatches=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Cuts a hang short
	initial begin
		#3000000;
		bad_count++;
		conclude;
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		rchk(`SSR_OFS_IRQ_ENABLE, 16'h0000);
		rchk(`SSR_OFS_IRQ_STATUS, 16'h0000);
		rchk(`SSR_OFS_CRC_CONTROL, 16'h0400);
		rchk(`SSR_OFS_IRQ_CLEAR, 16'h0000);
		rchk(16'hc0e0, 16'h0000);
		rchk(`SSR_OFS_PORT_CTRL, 16'h0080);
		rxFull <= 1'b1;
		rchk(`SSR_OFS_PORT_CTRL, 16'h00c0);
		$display("test reset values done");
		// Flags set while every enable is off
		for (int i = 0; i < 3; i++) begin
			pulse(4'h1 << i);
			irqchk(1'b0);
			rchk(`SSR_OFS_IRQ_STATUS, (16'h0002 << i) - 16'h0001);
		end
		// Each enable on its own lets the pending flags through
		for (int i = 0; i < 3; i++) begin
			wr(`SSR_OFS_IRQ_ENABLE, 16'h0001 << i);
			irqchk(1'b1);
		end
		wr(`SSR_OFS_IRQ_ENABLE, 16'h0000);
		irqchk(1'b0);
		wr(`SSR_OFS_IRQ_CLEAR, 16'h0004);
		rchk(`SSR_OFS_IRQ_STATUS, 16'h0007);
		wr(`SSR_OFS_IRQ_CLEAR, 16'h0002);
		rchk(`SSR_OFS_IRQ_STATUS, 16'h0005);
		wr(`SSR_OFS_IRQ_CLEAR, 16'h0001);
		rchk(`SSR_OFS_IRQ_STATUS, 16'h0004);
		rxDataReady <= 1'b0;
		rchk(`SSR_OFS_IRQ_STATUS, 16'h0000);
		rxDataReady <= 1'b1;
		$display("test flags and clears done");
		// All three events at once with all enables on
		wr(`SSR_OFS_IRQ_ENABLE, 16'h0007);
		rchk(`SSR_OFS_IRQ_ENABLE, 16'h0007);
		pulse(4'h7);
		irqchk(1'b1);
		wr(`SSR_OFS_IRQ_CLEAR, 16'h0003);
		rxDataReady <= 1'b0;
		pulse(4'h8);
		rxDataReady <= 1'b1;
		rchk(`SSR_OFS_IRQ_STATUS, 16'h0080);
		wr(`SSR_OFS_IRQ_CLEAR, 16'h0003);
		rchk(`SSR_OFS_IRQ_STATUS, 16'h0080);
		wr(`SSR_OFS_PORT_CTRL, 16'h4000);
		rchk(`SSR_OFS_IRQ_STATUS, 16'h0000);
		$display("test fifo error done");
		// Every defined polynomial select reads back
		for (int m = 0; m < 3; m++) begin
			wr(`SSR_OFS_CRC_CONTROL, 16'(m) << 14);
			rchk(`SSR_OFS_CRC_CONTROL, (16'(m) << 14) | 16'h0400);
		end
		wr(`SSR_OFS_CRC_CONTROL, 16'h2800);
		peer.frame(3, 8'hff);
		repeat (8) @(posedge core_clk);
		rchk(`SSR_OFS_PORT_CTRL, 16'h00db);
		rchk(`SSR_OFS_CRC_CONTROL, 16'h2e00);
		rchk(`SSR_OFS_CRC_VALUE, 16'h8f1f);
		// Transmit stream as source: mosi as master, miso as slave
		for (int s = 0; s < 2; s++) begin
			masterMode <= (s == 0);
			wr(`SSR_OFS_CRC_CONTROL, 16'h3000);
			peer.frame(3, 8'hff);
			repeat (8) @(posedge core_clk);
			rchk(`SSR_OFS_CRC_VALUE, s ? 16'h8f1f : 16'hfff8);
		end
		masterMode <= 1'b1;
		wr(`SSR_OFS_CRC_CONTROL, 16'h3800);
		rchk(`SSR_OFS_CRC_CONTROL, 16'h2c00);
		peer.frame(8, 8'ha5);
		repeat (8) @(posedge core_clk);
		rchk(`SSR_OFS_PORT_CTRL, 16'h00c0);
		// Half duplex receive frame: only the receive length moves, CRC7 on the rx line
		fullDuplex <= 1'b0;
		readEnable <= 1'b1;
		wr(`SSR_OFS_CRC_CONTROL, 16'h7000);
		peer.frame(3, 8'hff);
		repeat (8) @(posedge core_clk);
		rchk(`SSR_OFS_PORT_CTRL, 16'h00c3);
		rchk(`SSR_OFS_CRC_VALUE, 16'h0047);
		rchk(`SSR_OFS_CRC_CONTROL, 16'h6600);
		// Half duplex transmit frame: only the transmit length moves
		readEnable <= 1'b0;
		wr(`SSR_OFS_CRC_CONTROL, 16'hb000);
		peer.frame(5, 8'hff);
		repeat (8) @(posedge core_clk);
		rchk(`SSR_OFS_PORT_CTRL, 16'h00eb);
		rchk(`SSR_OFS_CRC_VALUE, 16'h7fa1);
		$display("test crc and link done");
		conclude;
	end
endmodule
